// ==== hdl/prr_bank.sv ====
// Regulator setting bank: register storage and decode into regulator controls
//
// Behaviour
// - Converter 3 limit 700 plus code times 100
// - Converter 1 limit 1400 plus code times 200
// - Half-current mode halves converter 1 limit
// - Mode field picks setting, PFM, PWM, automatic
// - Mode zero, A active: A sleep bit decides
// - Mode zero, B active: B sleep bit decides
// - Pull-down-disable bit keeps disabled rail's pull-down off
// - Converter 1 voltage 0.3 V, 10 mV steps
// - Converter 3 voltage 0.53 V, 10 mV steps
// - Converter 2 voltage 0.80 V, 20 mV steps
// - Linear regulator 0.90 V at 0x02, 50-mV steps
// - Linear regulator codes clamp to 0x02..0x38
// - Linear regulator A sleep bit forces sleep
// - Converter 2 limit 1700 plus code times 100
`timescale 1ns/100ps
`default_nettype none
`include "prr_cfg.svh"

module prr_bank #(
  parameter int NSD = 3,
  parameter int NLR = 4
) (
  // Clock, reset, enable
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        core_ce,
  // Register port from the serial interface
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [8:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  // Regulator state from the voltage-control logic
  input  wire logic [1:0]                  setting_b_sel,
  input  wire logic                        stepdown1_half_current,
  input  wire logic [NSD-1:0]              stepdown_enable,
  // Decoded controls for the analogue regulators
  output prr_pkg::prr_stepdown_t [NSD-1:0] stepdown_ctrl,
  output prr_pkg::prr_linreg_t   [NLR-1:0] linreg_ctrl
);

  localparam int IW = $clog2(`PRR_NREG);

  // Address to storage slot; misses write nothing and read zero
  function automatic logic [IW:0] addr_slot(input logic [8:0] addr);
    case (addr)
      `PRR_OFS_SD1_ILIM: addr_slot = {1'b1, 4'h0};
      `PRR_OFS_SD2_ILIM: addr_slot = {1'b1, 4'h1};
      `PRR_OFS_SD3_ILIM: addr_slot = {1'b1, 4'h2};
      `PRR_OFS_SD1_CFG:  addr_slot = {1'b1, 4'h3};
      `PRR_OFS_SD2_CFG:  addr_slot = {1'b1, 4'h4};
      `PRR_OFS_SD3_CFG:  addr_slot = {1'b1, 4'h5};
      `PRR_OFS_SD1_A:    addr_slot = {1'b1, 4'h6};
      `PRR_OFS_SD2_A:    addr_slot = {1'b1, 4'h7};
      `PRR_OFS_SD3_A:    addr_slot = {1'b1, 4'h8};
      `PRR_OFS_LR1_A:    addr_slot = {1'b1, 4'h9};
      `PRR_OFS_LR2_A:    addr_slot = {1'b1, 4'ha};
      `PRR_OFS_LR3_A:    addr_slot = {1'b1, 4'hb};
      `PRR_OFS_LR4_A:    addr_slot = {1'b1, 4'hc};
      `PRR_OFS_SD1_B:    addr_slot = {1'b1, `PRR_IDX_SD1_B};
      `PRR_OFS_SD3_B:    addr_slot = {1'b1, `PRR_IDX_SD3_B};
      default:           addr_slot = '0;
    endcase
  endfunction

  // Mode field plus the active setting's sleep bit to an operating mode
  function automatic prr_pkg::prr_op_t op_of(input logic [1:0] mode, input logic sleep);
    case (mode)
      `PRR_MODE_SETTING: op_of = sleep ? prr_pkg::PRR_OP_PFM : prr_pkg::PRR_OP_PWM;
      `PRR_MODE_PFM:     op_of = prr_pkg::PRR_OP_PFM;
      `PRR_MODE_PWM:     op_of = prr_pkg::PRR_OP_PWM;
      default:           op_of = prr_pkg::PRR_OP_AUTO;
    endcase
  endfunction

  logic [IW:0]                 slot;
  logic [`PRR_NREG-1:0][7:0]   regs;
  logic [NSD-1:0][3:0]         ilim_code;
  logic [NSD-1:0][1:0]         mode_code;
  logic [NSD-1:0]              pd_off;
  logic [NSD-1:0][7:0]         set_act;
  logic [NSD-1:0]              b_active;
  prr_pkg::prr_stepdown_t [NSD-1:0] next_stepdown;
  prr_pkg::prr_linreg_t   [NLR-1:0] next_linreg;

  // Same-clock port from the serial interface, so no synchroniser
  assign slot = addr_slot(reg_addr);

  prr_regfile #(
    .NREG (`PRR_NREG),
    .DW   (8),
    .IW   (IW)
  ) u_regs (
    .core_clk (core_clk),
    .reset    (reset),
    .core_ce  (core_ce),
    .wr_en    (reg_wr && slot[IW]),
    .wr_idx   (slot[IW-1:0]),
    .wr_data  (reg_wdata),
    .rd_en    (reg_rd),
    .rd_hit   (slot[IW]),
    .rd_idx   (slot[IW-1:0]),
    .rd_data  (reg_rdata),
    .contents (regs)
  );

  // Only converters 1 and 3 hold a B setting here; converter 2 stays on A
  assign b_active = {setting_b_sel[1], 1'b0, setting_b_sel[0]};

  // Per-converter field extraction and A/B choice
  genvar g;
  generate
    for (g = 0; g < NSD; g++)
    begin : g_sd
      assign ilim_code[g] = regs[`PRR_IDX_ILIM0 + 4'(g)][`PRR_ILIM_HI:0];
      assign mode_code[g] = regs[`PRR_IDX_CFG0 + 4'(g)][`PRR_MODE_HI:`PRR_MODE_LO];
      assign pd_off[g]    = regs[`PRR_IDX_CFG0 + 4'(g)][`PRR_PD_BIT];
      // B register in place of A while the rail's B setting is active
      if (g == 0)
      begin : g_b1
        assign set_act[g] = b_active[g] ? regs[`PRR_IDX_SD1_B] : regs[`PRR_IDX_SETA0];
      end
      else if (g == 2)
      begin : g_b3
        assign set_act[g] = b_active[g] ? regs[`PRR_IDX_SD3_B] : regs[`PRR_IDX_SETA0 + 4'h2];
      end
      else
      begin : g_a
        assign set_act[g] = regs[`PRR_IDX_SETA0 + 4'(g)];
      end
    end
  endgenerate

  // Step-down decode: limits, voltages, modes, pull-downs
  always_comb
  begin
    logic [12:0] lim1;
    lim1 = 13'(`PRR_SD1_ILIM_BASE + `PRR_SD1_ILIM_STEP * int'(ilim_code[0]));
    next_stepdown[0].limit_ma = stepdown1_half_current ? (lim1 >> 1) : lim1;
    next_stepdown[1].limit_ma =
      13'(`PRR_SD2_ILIM_BASE + `PRR_SD2_ILIM_STEP * int'(ilim_code[1]));
    next_stepdown[2].limit_ma =
      13'(`PRR_SD3_ILIM_BASE + `PRR_SD3_ILIM_STEP * int'(ilim_code[2]));
    next_stepdown[0].volt_mv =
      12'(`PRR_SD1_V_BASE + `PRR_SD1_V_STEP * int'(set_act[0][`PRR_SDV_HI:0]));
    next_stepdown[1].volt_mv =
      12'(`PRR_SD2_V_BASE + `PRR_SD2_V_STEP * int'(set_act[1][`PRR_SDV_HI:0]));
    next_stepdown[2].volt_mv =
      12'(`PRR_SD3_V_BASE + `PRR_SD3_V_STEP * int'(set_act[2][`PRR_SDV_HI:0]));
    for (int i = 0; i < NSD; i++)
    begin
      // Sleep bit of whichever setting is active
      next_stepdown[i].op = op_of(mode_code[i], set_act[i][`PRR_SLEEP_BIT]);
      // Pull-down only matters while the rail is off
      next_stepdown[i].pulldown_on = !stepdown_enable[i] && !pd_off[i];
    end
  end

  // Linear regulator decode; the clamp keeps reserved codes out of the analogue trim
  generate
    for (g = 0; g < NLR; g++)
    begin : g_lr
      logic [5:0] code;
      logic [5:0] clamped;
      assign code = regs[`PRR_IDX_LRA0 + 4'(g)][`PRR_LRV_HI:0];
      assign clamped = (code < `PRR_LR_CODE_MIN) ? `PRR_LR_CODE_MIN :
                       (code > `PRR_LR_CODE_MAX) ? `PRR_LR_CODE_MAX : code;
      assign next_linreg[g].volt_mv =
        12'(`PRR_LR_V_BASE + `PRR_LR_V_STEP * (int'(clamped) - int'(`PRR_LR_CODE_MIN)));
      // Only the A setting exists here, so it is always the selected one
      assign next_linreg[g].sleep = regs[`PRR_IDX_LRA0 + 4'(g)][`PRR_SLEEP_BIT];
    end
  endgenerate

  // Outputs registered so the analogue side never sees decode glitches
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stepdown_ctrl <= '0;
      linreg_ctrl   <= '0;
    end
    else if (core_ce)
    begin
      stepdown_ctrl <= next_stepdown;
      linreg_ctrl   <= next_linreg;
    end
  end

  // Reset seen at the last edge; outputs still hold their reset zeros one edge after
  // release, so look-back checks would fire there; follows reset even with enable low
  logic reset_q;
  always_ff @(posedge core_clk)
  begin
    reset_q <= reset;
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || reset_q);

  // A write lands in storage, then reaches the output one enabled edge later
  sequence s_write_sd3;
    core_ce && reg_wr && reg_addr == `PRR_OFS_SD3_ILIM;
  endsequence
  sequence s_two_enabled;
    core_ce ##1 core_ce;
  endsequence

  ilim3_path_a: assert property (
    s_write_sd3 ##0 s_two_enabled |=> stepdown_ctrl[2].limit_ma ==
      13'(`PRR_SD3_ILIM_BASE + `PRR_SD3_ILIM_STEP * int'($past(reg_wdata[3:0], 2))))
    else $error("converter 3 limit does not follow the written code");

  ilim1_half_a: assert property (
    core_ce |=> stepdown_ctrl[0].limit_ma == (13'(`PRR_SD1_ILIM_BASE +
      `PRR_SD1_ILIM_STEP * int'($past(ilim_code[0]))) >> $past(stepdown1_half_current)))
    else $error("converter 1 limit or half-current scaling wrong");

  ilim2_value_a: assert property (
    core_ce |=> stepdown_ctrl[1].limit_ma ==
      13'(`PRR_SD2_ILIM_BASE + `PRR_SD2_ILIM_STEP * int'($past(ilim_code[1]))))
    else $error("converter 2 limit wrong");

  mode_forced_a: assert property (
    core_ce && mode_code[1] != `PRR_MODE_SETTING |=>
      stepdown_ctrl[1].op == ($past(mode_code[1]) == `PRR_MODE_PFM ? prr_pkg::PRR_OP_PFM :
      $past(mode_code[1]) == `PRR_MODE_PWM ? prr_pkg::PRR_OP_PWM : prr_pkg::PRR_OP_AUTO))
    else $error("forced converter mode wrong");

  sleep_a_sel_a: assert property (
    core_ce && mode_code[0] == `PRR_MODE_SETTING && !setting_b_sel[0] |=>
      stepdown_ctrl[0].op == ($past(regs[`PRR_IDX_SETA0][`PRR_SLEEP_BIT]) ?
      prr_pkg::PRR_OP_PFM : prr_pkg::PRR_OP_PWM))
    else $error("A sleep bit not honoured");

  sleep_b_sel_a: assert property (
    core_ce && mode_code[2] == `PRR_MODE_SETTING && setting_b_sel[1] |=>
      stepdown_ctrl[2].op == ($past(regs[`PRR_IDX_SD3_B][`PRR_SLEEP_BIT]) ?
      prr_pkg::PRR_OP_PFM : prr_pkg::PRR_OP_PWM))
    else $error("B sleep bit not honoured");

  pulldown_off_a: assert property (
    core_ce && pd_off[1] |=> !stepdown_ctrl[1].pulldown_on)
    else $error("pull-down on although disabled by setting");

  volt1_b_a: assert property (
    core_ce && setting_b_sel[0] |=> stepdown_ctrl[0].volt_mv == 12'(`PRR_SD1_V_BASE +
      `PRR_SD1_V_STEP * int'($past(regs[`PRR_IDX_SD1_B][`PRR_SDV_HI:0]))))
    else $error("converter 1 B voltage wrong");

  volt3_a_a: assert property (
    core_ce && !setting_b_sel[1] |=> stepdown_ctrl[2].volt_mv == 12'(`PRR_SD3_V_BASE +
      `PRR_SD3_V_STEP * int'($past(regs[`PRR_IDX_SETA0 + 4'h2][`PRR_SDV_HI:0]))))
    else $error("converter 3 A voltage wrong");

  volt2_value_a: assert property (
    core_ce |=> stepdown_ctrl[1].volt_mv == 12'(`PRR_SD2_V_BASE +
      `PRR_SD2_V_STEP * int'($past(regs[`PRR_IDX_SETA0 + 4'h1][`PRR_SDV_HI:0]))))
    else $error("converter 2 voltage wrong");

  linreg_range_a: assert property (
    core_ce |=> linreg_ctrl[0].volt_mv >= 12'(`PRR_LR_V_BASE) &&
      linreg_ctrl[0].volt_mv <= 12'(3600) && (linreg_ctrl[0].volt_mv % 50) == 0)
    else $error("linear regulator voltage off grid");

  linreg_clamp_a: assert property (
    core_ce && regs[`PRR_IDX_LRA0][`PRR_LRV_HI:0] > `PRR_LR_CODE_MAX |=>
      linreg_ctrl[0].volt_mv == 12'(3600))
    else $error("linear regulator code not clamped");

  linreg_sleep_a: assert property (
    core_ce |=> linreg_ctrl[3].sleep == $past(regs[`PRR_IDX_LRA0 + 4'h3][`PRR_SLEEP_BIT]))
    else $error("linear regulator sleep not forced");

  sleep1_b_sel_a: assert property (
    core_ce && mode_code[0] == `PRR_MODE_SETTING && setting_b_sel[0] |=>
      stepdown_ctrl[0].op == ($past(regs[`PRR_IDX_SD1_B][`PRR_SLEEP_BIT]) ?
      prr_pkg::PRR_OP_PFM : prr_pkg::PRR_OP_PWM))
    else $error("converter 1 B sleep bit not honoured");

  volt1_a_a: assert property (
    core_ce && !setting_b_sel[0] |=> stepdown_ctrl[0].volt_mv == 12'(`PRR_SD1_V_BASE +
      `PRR_SD1_V_STEP * int'($past(regs[`PRR_IDX_SETA0][`PRR_SDV_HI:0]))))
    else $error("converter 1 A voltage wrong");

  volt3_b_a: assert property (
    core_ce && setting_b_sel[1] |=> stepdown_ctrl[2].volt_mv == 12'(`PRR_SD3_V_BASE +
      `PRR_SD3_V_STEP * int'($past(regs[`PRR_IDX_SD3_B][`PRR_SDV_HI:0]))))
    else $error("converter 3 B voltage wrong");

  mode3_pfm_a: assert property (
    core_ce && mode_code[2] == `PRR_MODE_PFM |=> stepdown_ctrl[2].op == prr_pkg::PRR_OP_PFM)
    else $error("converter 3 not held in PFM");

  pulldown_on_a: assert property (
    core_ce && !pd_off[0] && !stepdown_enable[0] |=> stepdown_ctrl[0].pulldown_on)
    else $error("pull-down missing on disabled converter 1");

  linreg_floor_a: assert property (
    core_ce && regs[`PRR_IDX_LRA0][`PRR_LRV_HI:0] < `PRR_LR_CODE_MIN |=>
      linreg_ctrl[0].volt_mv == 12'(`PRR_LR_V_BASE))
    else $error("low linear regulator code not clamped");

  // Enable low freezes every control output
  ce_hold_a: assert property (
    !core_ce |=> $stable(stepdown_ctrl) && $stable(linreg_ctrl))
    else $error("outputs moved while the clock enable was low");

endmodule
`default_nettype wire

// ==== hdl/prr_cfg.svh ====
// Offsets, field positions, reset values and scale figures of the regulator setting bank
`ifndef PRR_CFG_SVH
`define PRR_CFG_SVH

// Register offsets
`define PRR_OFS_SD2_ILIM   9'h09a
`define PRR_OFS_SD3_ILIM   9'h09b
`define PRR_OFS_SD1_ILIM   9'h09c
`define PRR_OFS_SD1_CFG    9'h09e
`define PRR_OFS_SD3_CFG    9'h09f
`define PRR_OFS_SD2_CFG    9'h0a0
`define PRR_OFS_SD1_A      9'h0a4
`define PRR_OFS_SD3_A      9'h0a5
`define PRR_OFS_SD2_A      9'h0a7
`define PRR_OFS_LR1_A      9'h0a9
`define PRR_OFS_LR2_A      9'h0aa
`define PRR_OFS_LR3_A      9'h0ab
`define PRR_OFS_LR4_A      9'h0ac
`define PRR_OFS_SD1_B      9'h0b5
`define PRR_OFS_SD3_B      9'h0b6

// Storage slots; converters are numbered 0..2 for rails 1..3
`define PRR_NREG           15
`define PRR_IDX_ILIM0      4'h0
`define PRR_IDX_CFG0       4'h3
`define PRR_IDX_SETA0      4'h6
`define PRR_IDX_LRA0       4'h9
`define PRR_IDX_SD1_B      4'hd
`define PRR_IDX_SD3_B      4'he

// Field positions
`define PRR_ILIM_HI        3
`define PRR_MODE_HI        7
`define PRR_MODE_LO        6
`define PRR_PD_BIT         5
`define PRR_SLEEP_BIT      7
`define PRR_SDV_HI         6
`define PRR_LRV_HI         5

// Reset value of every register
`define PRR_REG_RESET      8'h00

// Current limit base and step in mA, converters 1..3
`define PRR_SD1_ILIM_BASE  1400
`define PRR_SD1_ILIM_STEP  200
`define PRR_SD2_ILIM_BASE  1700
`define PRR_SD2_ILIM_STEP  100
`define PRR_SD3_ILIM_BASE  700
`define PRR_SD3_ILIM_STEP  100

// Output voltage base and step in mV
`define PRR_SD1_V_BASE     300
`define PRR_SD1_V_STEP     10
`define PRR_SD2_V_BASE     800
`define PRR_SD2_V_STEP     20
`define PRR_SD3_V_BASE     530
`define PRR_SD3_V_STEP     10
`define PRR_LR_V_BASE      900
`define PRR_LR_V_STEP      50
`define PRR_LR_CODE_MIN    6'h02
`define PRR_LR_CODE_MAX    6'h38

// Mode field codes
`define PRR_MODE_SETTING   2'h0
`define PRR_MODE_PFM       2'h1
`define PRR_MODE_PWM       2'h2

`endif

// ==== hdl/prr_pkg.sv ====
// Types shared by the regulator setting bank
package prr_pkg;

  // Operating mode handed to a step-down converter
  typedef enum logic [1:0] {PRR_OP_PFM, PRR_OP_PWM, PRR_OP_AUTO} prr_op_t;

  // Control bundle of one step-down converter
  typedef struct packed {
    logic [12:0] limit_ma;
    logic [11:0] volt_mv;
    prr_op_t     op;
    logic        pulldown_on;
  } prr_stepdown_t;

  // Control bundle of one linear regulator
  typedef struct packed {
    logic [11:0] volt_mv;
    logic        sleep;
  } prr_linreg_t;

endpackage

// ==== hdl/prr_regfile.sv ====
// Byte register storage with one write port, registered read and parallel contents
`timescale 1ns/100ps
`default_nettype none
`include "prr_cfg.svh"

module prr_regfile #(
  parameter int NREG = `PRR_NREG,
  parameter int DW   = 8,
  parameter int IW   = $clog2(NREG)
) (
  // Clock and control
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   core_ce,
  // Write port
  input  wire logic                   wr_en,
  input  wire logic [IW-1:0]          wr_idx,
  input  wire logic [DW-1:0]          wr_data,
  // Read port
  input  wire logic                   rd_en,
  input  wire logic                   rd_hit,
  input  wire logic [IW-1:0]          rd_idx,
  output logic      [DW-1:0]          rd_data,
  // All words at once for the decoders
  output logic      [NREG-1:0][DW-1:0] contents
);

  // Storage; every slot clears at reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
      contents <= '{default: `PRR_REG_RESET};
    else if (core_ce && wr_en && (int'(wr_idx) < NREG))
      contents[wr_idx] <= wr_data;
  end

  // Read data held until the next read; a miss answers zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      rd_data <= '0;
    else if (core_ce && rd_en)
      rd_data <= (rd_hit && (int'(rd_idx) < NREG)) ? contents[rd_idx] : '0;
  end

endmodule
`default_nettype wire

// ==== tb/prr_bank_tb.sv ====
// Self-checking testbench of the regulator setting bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
  typedef struct {logic [8:0] a; logic [7:0] d; int k; int i; int e;} prr_row_t;

  // Design inputs
  logic                            core_clk;
  logic                            reset = 1'b1;
  logic                            core_ce = 1'b1;
  logic                            reg_wr = 1'b0;
  logic                            reg_rd = 1'b0;
  logic [8:0]                      reg_addr = 9'h000;
  logic [7:0]                      reg_wdata = 8'h00;
  logic [1:0]                      setting_b_sel = 2'h0;
  logic                            stepdown1_half_current = 1'b0;
  logic [2:0]                      stepdown_enable = 3'h0;
  // Design outputs
  logic [7:0]                      reg_rdata;
  prr_pkg::prr_stepdown_t [2:0]    stepdown_ctrl;
  prr_pkg::prr_linreg_t   [3:0]    linreg_ctrl;
  int                              num_errors = 0;
  int                              compares = 0;

  // Rows run in order; register state carries over from one row to the next
  // Kinds: 0 limit, 1 converter volt, 2 linreg volt, 3 op, 4 linreg sleep, 5 pulldown
  prr_row_t rows [26] = '{
    '{9'h09b, 8'h0f, 0, 2, 2200}, '{9'h09b, 8'hf3, 0, 2, 1000},
    '{9'h09c, 8'h0f, 0, 0, 4400},
    '{9'h09a, 8'h0f, 0, 1, 3200},
    '{9'h0a4, 8'h7f, 1, 0, 1570},
    '{9'h0a5, 8'h7f, 1, 2, 1800},
    '{9'h0a7, 8'h7f, 1, 1, 3340},
    '{9'h0a0, 8'h80, 3, 1, 1}, '{9'h0a0, 8'h40, 3, 1, 0},
    '{9'h0a0, 8'hc0, 3, 1, 2}, '{9'h0a0, 8'h00, 3, 1, 1},
    '{9'h0a7, 8'hff, 3, 1, 0},
    '{9'h09f, 8'h40, 3, 2, 0}, '{9'h09f, 8'hc0, 3, 2, 2},
    '{9'h09e, 8'hc0, 3, 0, 2}, '{9'h09e, 8'h40, 3, 0, 0},
    '{9'h09e, 8'h20, 5, 0, 0}, '{9'h09e, 8'h00, 5, 0, 1},
    '{9'h0a9, 8'h00, 2, 0, 900}, '{9'h0ab, 8'h3f, 2, 2, 3600},
    '{9'h0aa, 8'h38, 2, 1, 3600}, '{9'h0ac, 8'h50, 2, 3, 1600},
    '{9'h0ac, 8'h03, 2, 3, 950}, '{9'h0aa, 8'h02, 2, 1, 900},
    '{9'h0a9, 8'h81, 4, 0, 1}, '{9'h0a9, 8'h01, 4, 0, 0}
  };

  prr_bank dut_u (
    .core_clk               (core_clk),
    .reset                  (reset),
    .core_ce                (core_ce),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_rdata              (reg_rdata),
    .setting_b_sel          (setting_b_sel),
    .stepdown1_half_current (stepdown1_half_current),
    .stepdown_enable        (stepdown_enable),
    .stepdown_ctrl          (stepdown_ctrl),
    .linreg_ctrl            (linreg_ctrl)
  );

  // Free-running 10 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Strobe is held for exactly one edge, then dropped on the next
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 check(13'(reg_rdata), 13'(exp));
  endtask

  // Decoded outputs lag storage by one more enabled edge
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [12:0] pick(input int k, input int i);
    case (k)
      0: return stepdown_ctrl[i].limit_ma;
      1: return 13'(stepdown_ctrl[i].volt_mv);
      2: return 13'(linreg_ctrl[i].volt_mv);
      3: return 13'(stepdown_ctrl[i].op);
      4: return 13'(linreg_ctrl[i].sleep);
      default: return 13'(stepdown_ctrl[i].pulldown_on);
    endcase
  endfunction

  // Hang guard, far beyond the length of the sequence
  initial
  begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[n])
    begin
      wr(rows[n].a, rows[n].d);
      settle();
      check(pick(rows[n].k, rows[n].i), 13'(rows[n].e));
      rd(rows[n].a, rows[n].d);
    end
    // Half-current mode halves the programmed converter 1 limit
    @(posedge core_clk);
    stepdown1_half_current <= 1'b1;
    settle();
    check(pick(0, 0), 13'h898);
    @(posedge core_clk);
    stepdown1_half_current <= 1'b0;
    // A and B settings chosen per rail by the select input
    wr(9'h0a4, 8'h0a);
    wr(9'h0b5, 8'h85);
    settle();
    check(pick(1, 0), 13'h190);
    check(pick(3, 0), 13'h001);
    @(posedge core_clk);
    setting_b_sel <= 2'h1;
    settle();
    check(pick(1, 0), 13'h15e);
    check(pick(3, 0), 13'h000);
    wr(9'h0a5, 8'h81);
    wr(9'h0b6, 8'h00);
    wr(9'h09f, 8'h00);
    setting_b_sel <= 2'h2;
    settle();
    check(pick(1, 2), 13'h212);
    check(pick(3, 2), 13'h001);
    check(pick(1, 0), 13'h190);
    @(posedge core_clk);
    setting_b_sel <= 2'h0;
    settle();
    check(pick(3, 2), 13'h000);
    check(pick(1, 2), 13'h21c);
    // Pull-down only acts on a disabled rail whose disable bit is clear
    wr(9'h0a0, 8'h20);
    stepdown_enable <= 3'h2;
    settle();
    check(pick(5, 1), 13'h000);
    wr(9'h0a0, 8'h00);
    settle();
    check(pick(5, 1), 13'h000);
    @(posedge core_clk);
    stepdown_enable <= 3'h0;
    settle();
    check(pick(5, 1), 13'h001);
    // Write then read next cycle, then write and read in one cycle
    wr(9'h09b, 8'h03);
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(13'(reg_rdata), 13'h003);
    @(posedge core_clk);
    reg_wdata <= 8'h07;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    #1 check(13'(reg_rdata), 13'h003);
    rd(9'h09b, 8'h07);
    // Write strobe ignored while the clock enable is low
    @(posedge core_clk);
    core_ce <= 1'b0;
    wr(9'h0a9, 8'h38);
    core_ce <= 1'b1;
    rd(9'h0a9, 8'h01);
    // Unmapped offset neither stores nor reads back
    wr(9'h09d, 8'h55);
    rd(9'h09d, 8'h00);
    // Second reset in mid-run restores zeros and their decode
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(9'h09b, 8'h00);
    rd(9'h0a4, 8'h00);
    settle();
    check(pick(0, 2), 13'h2bc);
    check(pick(0, 1), 13'h6a4);
    check(pick(1, 0), 13'h12c);
    check(pick(1, 1), 13'h320);
    check(pick(2, 3), 13'h384);
    check(pick(3, 2), 13'h001);
    close_out();
  end
endmodule

`default_nettype wire
